// ===== verilog/parity_clk_cfg.svh
// constants for operand parity checking and register clocking
`ifndef PARITY_CLK_CFG_SVH
`define PARITY_CLK_CFG_SVH

// ****************************************************************
// bus layout
// ****************************************************************
`define CFG_WORD_W    32
`define CFG_BYTE_W    8
`define CFG_PAR_W     4
`define CFG_TEMP_W    64
`define CFG_TEMP_HI   63
`define CFG_TEMP_MID  32

// ****************************************************************
// reset values
// ****************************************************************
`define CFG_WORD_RST  32'h0000_0000
`define CFG_TEMP_RST  64'h0000_0000_0000_0000
`define CFG_PAR_RST   4'h0
`define CFG_SYNC_RST  3'h0

// ****************************************************************
// timing: pin synchroniser depth
// ****************************************************************
`define CFG_SYNC_STAGES 3

`endif

// ===== verilog/parity_clk_pkg.sv
// types for operand parity checking and register clocking
`include "parity_clk_cfg.svh"

package parity_clk_pkg;

  // one operand bus beat with its parity lines
  typedef struct packed {
    logic [`CFG_WORD_W-1:0] data;
    logic [`CFG_PAR_W-1:0]  par;
  } operand_beat_t;

  // source of an input register load
  typedef enum logic [1:0] {
    SRC_DIRECT = 2'b01,
    SRC_TEMP   = 2'b10
  } load_src_t;

endpackage : parity_clk_pkg

// ===== verilog/even_parity_check.sv
// even parity check of one 32-bit bus, per byte or per word
`include "parity_clk_cfg.svh"

module even_parity_check
  import parity_clk_pkg::*;
(
  // checked beat
  input  wire operand_beat_t beat,
  // mode
  input  wire logic          byte_mode,
  // result
  output wire logic          parity_fail
);

  logic [`CFG_PAR_W-1:0] byte_fail;
  logic                  word_fail;

  // ****************************************************************
  // per-byte groups, each with its own parity bit
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < `CFG_PAR_W; i = i + 1) begin : g_byte
      assign byte_fail[i] = ^{beat.data[i*`CFG_BYTE_W +: `CFG_BYTE_W], beat.par[i]};
    end
  endgenerate

  // whole word covered by the lowest parity bit
  assign word_fail   = ^{beat.data, beat.par[0]};
  assign parity_fail = byte_mode ? (|byte_fail) : word_fail;

endmodule : even_parity_check

// ===== verilog/operand_parity_clocking.sv
// operand capture, even parity checking, result hold register and y port
`include "parity_clk_cfg.svh"

module operand_parity_clocking
  import parity_clk_pkg::*;
(
  // clock, reset, freeze
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // operand buses and parity
  input  wire logic [`CFG_WORD_W-1:0] first_operand_bus,
  input  wire logic [`CFG_PAR_W-1:0]  first_bus_parity_in,
  input  wire logic [`CFG_WORD_W-1:0] second_operand_bus,
  input  wire logic [`CFG_PAR_W-1:0]  second_bus_parity_in,
  // capture control
  input  wire logic                   byte_parity_select,
  input  wire logic                   temp_load_edge_select,
  input  wire logic                   temp_load,
  input  wire logic                   first_load,
  input  wire logic                   second_load,
  input  wire load_src_t              load_source,
  // captured operands and parity status
  output wire logic [`CFG_WORD_W-1:0] first_input_data,
  output wire logic [`CFG_WORD_W-1:0] second_input_data,
  output wire logic [`CFG_TEMP_W-1:0] temp_data,
  output wire logic                   first_bus_parity_error,
  output wire logic                   second_bus_parity_error,
  // result hold register
  input  wire logic                   result_hold_clock,
  input  wire logic                   result_hold_write_en_n,
  input  wire logic [`CFG_WORD_W-1:0] result_in,
  // y bus, two-way
  input  wire logic                   y_output_enable_n,
  input  wire logic [`CFG_WORD_W-1:0] y_in,
  output wire logic [`CFG_WORD_W-1:0] y_out,
  output wire logic                   y_oe,
  input  wire logic [`CFG_PAR_W-1:0]  result_bus_parity_in,
  output wire logic [`CFG_PAR_W-1:0]  result_bus_parity_out,
  output wire logic                   result_bus_parity_oe,
  // lockstep check
  output wire logic                   lockstep_mismatch_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [`CFG_TEMP_W-1:0]       temp_rise_reg;
  logic [`CFG_TEMP_W-1:0]       temp_fall_reg;
  logic [`CFG_WORD_W-1:0]       first_input_reg;
  logic [`CFG_WORD_W-1:0]       second_input_reg;
  logic                         first_err_reg;
  logic                         second_err_reg;
  logic [`CFG_WORD_W-1:0]       hold_reg;
  logic [`CFG_PAR_W-1:0]        hold_par_reg;
  logic                         mismatch_reg;
  logic [`CFG_SYNC_STAGES-1:0]  hclk_sync_reg;
  logic [`CFG_SYNC_STAGES-1:0]  hwe_sync_reg;
  logic                         hclk_level_reg;

  // ****************************************************************
  // parity checks on the live buses
  // ****************************************************************
  operand_beat_t first_beat;
  operand_beat_t second_beat;
  logic          first_fail;
  logic          second_fail;

  assign first_beat  = '{data: first_operand_bus, par: first_bus_parity_in};
  assign second_beat = '{data: second_operand_bus, par: second_bus_parity_in};

  even_parity_check u_first_check (
    .beat        (first_beat),
    .byte_mode   (byte_parity_select),
    .parity_fail (first_fail)
  );

  even_parity_check u_second_check (
    .beat        (second_beat),
    .byte_mode   (byte_parity_select),
    .parity_fail (second_fail)
  );

  // ****************************************************************
  // decode of loads and sources
  // ****************************************************************
  wire                   any_load     = temp_load | first_load | second_load;
  wire                   from_temp    = (load_source == SRC_TEMP);
  wire [`CFG_TEMP_W-1:0] live_pair    = {first_operand_bus, second_operand_bus};
  wire [`CFG_TEMP_W-1:0] temp_view    = temp_load_edge_select ? temp_fall_reg : temp_rise_reg;
  wire [`CFG_WORD_W-1:0] first_next   = from_temp ? temp_view[`CFG_TEMP_HI:`CFG_TEMP_MID]
                                                  : first_operand_bus;
  wire [`CFG_WORD_W-1:0] second_next  = from_temp ? temp_view[`CFG_TEMP_MID-1:0]
                                                  : second_operand_bus;

  // temporary register, rising-edge copy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_rise_reg <= `CFG_TEMP_RST;
    end else if (clk_en && temp_load && !temp_load_edge_select) begin
      temp_rise_reg <= live_pair;
    end
  end

  // temporary register, falling-edge copy
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      temp_fall_reg <= `CFG_TEMP_RST;
    end else if (clk_en && temp_load && temp_load_edge_select) begin
      temp_fall_reg <= live_pair;
    end
  end

  // input registers, direct or from temporary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_input_reg  <= `CFG_WORD_RST;
      second_input_reg <= `CFG_WORD_RST;
    end else if (clk_en) begin
      if (first_load) begin
        first_input_reg <= first_next;
      end
      if (second_load) begin
        second_input_reg <= second_next;
      end
    end
  end

  // both error flags follow the live bus checks on any temporary or input register load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      first_err_reg  <= 1'b0;
      second_err_reg <= 1'b0;
    end else if (clk_en && any_load) begin
      first_err_reg  <= first_fail;
      second_err_reg <= second_fail;
    end
  end

  // ****************************************************************
  // result hold clock: three-stage pin synchroniser
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hclk_sync_reg <= `CFG_SYNC_RST;
      hwe_sync_reg  <= `CFG_SYNC_RST;
    end else if (clk_en) begin
      hclk_sync_reg <= {hclk_sync_reg[1:0], result_hold_clock};
      hwe_sync_reg  <= {hwe_sync_reg[1:0], result_hold_write_en_n};
    end
  end

  // level accepted once stages two and three agree
  wire hclk_agree = (hclk_sync_reg[1] == hclk_sync_reg[2]);
  wire hclk_rise  = hclk_agree && hclk_sync_reg[2] && !hclk_level_reg;
  wire hwe_low    = !hwe_sync_reg[2] && !hwe_sync_reg[1];
  wire hold_write = hclk_rise && hwe_low;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hclk_level_reg <= 1'b0;
    end else if (clk_en && hclk_agree) begin
      hclk_level_reg <= hclk_sync_reg[2];
    end
  end

  // ****************************************************************
  // result hold register and y parity
  // ****************************************************************
  function automatic logic [`CFG_PAR_W-1:0] gen_parity(
    input logic [`CFG_WORD_W-1:0] word,
    input logic                   byte_mode
  );
    logic [`CFG_PAR_W-1:0] bits;
    bits = `CFG_PAR_RST;
    if (byte_mode) begin
      for (int k = 0; k < `CFG_PAR_W; k++) begin
        bits[k] = ^word[k*`CFG_BYTE_W +: `CFG_BYTE_W];
      end
    end else begin
      bits[0] = ^word;
    end
    return bits;
  endfunction : gen_parity

  // written only on a qualified hold clock edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg     <= `CFG_WORD_RST;
      hold_par_reg <= `CFG_PAR_RST;
    end else if (clk_en && hold_write) begin
      hold_reg     <= result_in;
      hold_par_reg <= gen_parity(result_in, byte_parity_select);
    end
  end

  // lockstep compare of the y pins against our own drive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mismatch_reg <= 1'b0;
    end else if (clk_en) begin
      mismatch_reg <= y_oe && ((y_in != hold_reg) ||
                               (result_bus_parity_in != hold_par_reg));
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign first_input_data        = first_input_reg;
  assign second_input_data       = second_input_reg;
  assign temp_data               = temp_view;
  assign first_bus_parity_error  = first_err_reg;
  assign second_bus_parity_error = second_err_reg;
  assign y_out                   = hold_reg;
  assign result_bus_parity_out   = hold_par_reg;
  assign y_oe                    = !y_output_enable_n;
  assign result_bus_parity_oe    = !y_output_enable_n;
  assign lockstep_mismatch_out   = mismatch_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_first_err_track: assert property (@(posedge clk) disable iff (rst)
    (clk_en && any_load) |=> (first_bus_parity_error == $past(first_fail)))
    else $error("first bus error does not follow its check");

  a_second_err_track: assert property (@(posedge clk) disable iff (rst)
    (clk_en && any_load) |=> (second_bus_parity_error == $past(second_fail)))
    else $error("second bus error does not follow its check");

  a_err_hold_idle: assert property (@(posedge clk) disable iff (rst)
    (!any_load || !clk_en) |=> $stable(first_bus_parity_error))
    else $error("error flag moved without a load");

  a_byte_group_fail: assert property (@(posedge clk) disable iff (rst)
    (clk_en && any_load && byte_parity_select &&
     ^{first_operand_bus[15:8], first_bus_parity_in[1]}) |=> first_bus_parity_error)
    else $error("odd byte group not flagged");

  a_word_fail: assert property (@(posedge clk) disable iff (rst)
    (clk_en && any_load && !byte_parity_select &&
     ^{second_operand_bus, second_bus_parity_in[0]}) |=> second_bus_parity_error)
    else $error("odd word not flagged");

  a_even_clean: assert property (@(posedge clk) disable iff (rst)
    (clk_en && any_load && !byte_parity_select &&
     !(^{first_operand_bus, first_bus_parity_in[0]})) |=> !first_bus_parity_error)
    else $error("even word flagged as error");

  a_temp_rise_load: assert property (@(posedge clk) disable iff (rst)
    (clk_en && temp_load && !temp_load_edge_select) |=> (temp_rise_reg == $past(live_pair)))
    else $error("rising edge temporary load missed");

  a_temp_fall_load: assert property (@(negedge clk) disable iff (rst)
    (clk_en && temp_load && temp_load_edge_select) |=> (temp_fall_reg == $past(live_pair)))
    else $error("falling edge temporary load missed");

  a_direct_load: assert property (@(posedge clk) disable iff (rst)
    (clk_en && first_load && load_source == SRC_DIRECT) |=>
    (first_input_data == $past(first_operand_bus)))
    else $error("direct load did not capture the bus");

  a_hold_write: assert property (@(posedge clk) disable iff (rst)
    (clk_en && hold_write) |=> (y_out == $past(result_in)))
    else $error("hold register write lost");

  a_hold_guard: assert property (@(posedge clk) disable iff (rst)
    (!hold_write || hwe_sync_reg[2]) |=> $stable(y_out))
    else $error("hold register changed without its clock");

  a_y_parity: assert property (@(posedge clk) disable iff (rst)
    (clk_en && hold_write) |=>
    (result_bus_parity_out == gen_parity(y_out, $past(byte_parity_select))))
    else $error("y parity does not match y data");

  a_mismatch_flag: assert property (@(posedge clk) disable iff (rst)
    (clk_en && y_oe && (y_in != y_out)) |=> lockstep_mismatch_out)
    else $error("lockstep mismatch not reported");

  c_byte_error: cover property (@(posedge clk) disable iff (rst)
    clk_en && any_load && byte_parity_select ##1 first_bus_parity_error);

  c_fall_then_load: cover property (@(posedge clk) disable iff (rst)
    clk_en && temp_load && temp_load_edge_select ##1 first_load && from_temp);

  c_hold_then_drive: cover property (@(posedge clk) disable iff (rst)
    hold_write ##[1:4] y_oe);

endmodule : operand_parity_clocking

// ===== test/host_operand_model.sv
// host model: operand buses with even parity, y pin resolution
`include "parity_clk_cfg.svh"

module host_operand_model
  import parity_clk_pkg::*;
(
  // values and injected faults from the bench
  input  wire logic [`CFG_WORD_W-1:0] first_word,
  input  wire logic [`CFG_WORD_W-1:0] second_word,
  input  wire logic                   byte_mode,
  input  wire logic [`CFG_PAR_W-1:0]  first_bad,
  input  wire logic [`CFG_PAR_W-1:0]  second_bad,
  input  wire logic [`CFG_WORD_W-1:0] y_fight,
  // operand pins
  output wire logic [`CFG_WORD_W-1:0] first_operand_bus,
  output wire logic [`CFG_PAR_W-1:0]  first_bus_parity_in,
  output wire logic [`CFG_WORD_W-1:0] second_operand_bus,
  output wire logic [`CFG_PAR_W-1:0]  second_bus_parity_in,
  // y pins
  input  wire logic [`CFG_WORD_W-1:0] y_out,
  input  wire logic                   y_oe,
  input  wire logic [`CFG_PAR_W-1:0]  result_bus_parity_out,
  input  wire logic                   result_bus_parity_oe,
  output wire logic [`CFG_WORD_W-1:0] y_in,
  output wire logic [`CFG_PAR_W-1:0]  result_bus_parity_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // even parity per byte, or bit 0 over the word with junk in unused bits
  function automatic logic [3:0] even_par(input logic [31:0] w, input logic bm);
    if (bm) begin
      return {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
    end
    return {3'h5, ^w};
  endfunction : even_par

  // operand pins, faults flip chosen parity bits
  assign first_operand_bus    = first_word;
  assign second_operand_bus   = second_word;
  assign first_bus_parity_in  = even_par(first_word, byte_mode) ^ first_bad;
  assign second_bus_parity_in = even_par(second_word, byte_mode) ^ second_bad;

  // driven pins show the device value, a fight flips bits; released pins invert
  assign y_in                 = y_oe ? (y_out ^ y_fight) : ~y_out;
  assign result_bus_parity_in = result_bus_parity_oe ? result_bus_parity_out
                                                     : ~result_bus_parity_out;
endmodule : host_operand_model

// ===== test/operand_parity_clocking_tb.sv
// self-checking bench for operand parity checking and register clocking
`include "parity_clk_cfg.svh"

module operand_parity_clocking_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import parity_clk_pkg::*;

  logic        clk = 0, rst = 1, clk_en = 1, byte_parity_select = 0;
  logic        temp_load_edge_select = 0, temp_load = 0, first_load = 0, second_load = 0;
  load_src_t   load_source = SRC_DIRECT;
  logic        result_hold_clock = 0, result_hold_write_en_n = 1, y_output_enable_n = 1;
  logic [31:0] first_word = 0, second_word = 0, result_in = 0, y_fight = 0;
  logic [3:0]  first_bad = 0, second_bad = 0;
  wire  [31:0] first_operand_bus, second_operand_bus, first_input_data, second_input_data;
  wire  [31:0] y_in, y_out;
  wire  [3:0]  first_bus_parity_in, second_bus_parity_in;
  wire  [3:0]  result_bus_parity_in, result_bus_parity_out;
  wire  [63:0] temp_data;
  wire         first_bus_parity_error, second_bus_parity_error, y_oe;
  wire         result_bus_parity_oe, lockstep_mismatch_out;
  int          error_cnt = 0, checks = 0;

  operand_parity_clocking dut (.*);
  host_operand_model hm (.byte_mode(byte_parity_select), .*);

  initial begin
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // helper tasks
  // ****************************************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // direct load of both buses with chosen parity faults
  task automatic op_case(input logic [31:0] a, b, input logic bm, input logic [3:0] ba, bb);
    first_word <= a;
    second_word <= b;
    byte_parity_select <= bm;
    first_bad <= ba;
    second_bad <= bb;
    load_source <= SRC_DIRECT;
    first_load <= 1;
    second_load <= 1;
    @(negedge clk);
    check(first_input_data, a, "first input register");
    check(second_input_data, b, "second input register");
    check(first_bus_parity_error, bm ? |ba : ba[0], "first bus error");
    check(second_bus_parity_error, bm ? |bb : bb[0], "second bus error");
    first_load <= 0;
    second_load <= 0;
    @(negedge clk);
  endtask : op_case

  // one hold clock pulse, high and low five cycles each
  task automatic hold_pulse();
    result_hold_clock <= 1;
    repeat (5) @(negedge clk);
    result_hold_clock <= 0;
    repeat (5) @(negedge clk);
  endtask : hold_pulse

  task automatic wait_y(input logic [31:0] exp);
    int n;
    n = 0;
    while (y_out !== exp && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (y_out !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: hold register never updated", $time);
      finish_test();
    end
  endtask : wait_y

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(negedge clk);
    rst <= 0;
    @(negedge clk);
    check(y_out, 0, "y after reset");
    check(first_bus_parity_error | second_bus_parity_error, 0, "errors after reset");
    check(y_oe, 0, "y enable follows pin");
    $display("reset test done");
    // word mode: upper parity bits ignored, bit 0 faults seen
    op_case(32'h1234_5678, 32'hA5A5_0F0F, 0, 4'h0, 4'h0);
    op_case(32'h1234_5678, 32'hA5A5_0F0F, 0, 4'hE, 4'hE);
    op_case(32'hFFFF_0001, 32'h8000_0000, 0, 4'h1, 4'h0);
    op_case(32'hFFFF_0001, 32'h8000_0000, 0, 4'h0, 4'h1);
    // byte mode: each byte alone, then two bad bytes that cancel over the word
    for (int i = 0; i < 4; i++) begin
      op_case(32'hDEAD_BEEF, 32'h0102_0408, 1, 4'h1 << i, 4'h8 >> i);
    end
    op_case(32'hDEAD_BEEF, 32'h0102_0408, 1, 4'h3, 4'h0);
    op_case(32'hDEAD_BEEF, 32'h0102_0408, 1, 4'h0, 4'h0);
    $display("parity test done");
    // clock enable low freezes the input registers
    clk_en <= 0;
    first_word <= 32'h5555_AAAA;
    first_load <= 1;
    @(negedge clk);
    check(first_input_data, 32'hDEAD_BEEF, "frozen register");
    clk_en <= 1;
    first_load <= 0;
    @(negedge clk);
    // temp register at rising edge, then input registers from temp
    temp_load_edge_select <= 0;
    first_word <= 32'h0BAD_CAFE;
    second_word <= 32'h7654_3210;
    temp_load <= 1;
    @(negedge clk);
    check(temp_data, 64'h0BAD_CAFE_7654_3210, "temp rising load");
    temp_load <= 0;
    first_word <= 32'h1111_1111;
    second_word <= 32'h2222_2222;
    load_source <= SRC_TEMP;
    first_load <= 1;
    second_load <= 1;
    @(negedge clk);
    check(first_input_data, 32'h0BAD_CAFE, "first from temp");
    check(second_input_data, 32'h7654_3210, "second from temp");
    first_load <= 0;
    second_load <= 0;
    // temp register at falling edge only
    temp_load_edge_select <= 1;
    temp_load <= 1;
    @(posedge clk);
    #1;
    check(temp_data, 64'h0, "no rising load in falling mode");
    @(negedge clk);
    temp_load <= 0;
    @(posedge clk);
    #1;
    check(temp_data, 64'h1111_1111_2222_2222, "temp falling load");
    @(negedge clk);
    // back to rising mode: the rising copy must not have moved
    temp_load_edge_select <= 0;
    @(negedge clk);
    check(temp_data, 64'h0BAD_CAFE_7654_3210, "rising copy kept");
    $display("temp test done");
    // hold register: write, no write without its clock, no write when disabled
    byte_parity_select <= 1;
    result_in <= 32'hC2A5_0F80;
    result_hold_write_en_n <= 0;
    hold_pulse();
    wait_y(32'hC2A5_0F80);
    check(y_out, 32'hC2A5_0F80, "hold write");
    check(result_bus_parity_out, 4'h9, "y parity per byte");
    result_in <= 32'h0000_00FF;
    repeat (10) @(negedge clk);
    check(y_out, 32'hC2A5_0F80, "hold needs its clock");
    result_hold_write_en_n <= 1;
    hold_pulse();
    repeat (5) @(negedge clk);
    check(y_out, 32'hC2A5_0F80, "hold write disabled");
    // word mode write: one parity bit over the whole result
    byte_parity_select <= 0;
    result_in <= 32'h0000_0001;
    result_hold_write_en_n <= 0;
    hold_pulse();
    wait_y(32'h0000_0001);
    check(result_bus_parity_out, 4'h1, "y parity per word");
    result_hold_write_en_n <= 1;
    $display("hold test done");
    // lockstep: a fought pin while driving, then while released
    y_output_enable_n <= 0;
    @(negedge clk);
    check(y_oe, 1, "y driven");
    check(lockstep_mismatch_out, 0, "quiet lockstep");
    y_fight <= 32'h0001_0000;
    @(negedge clk);
    check(lockstep_mismatch_out, 1, "lockstep mismatch");
    y_fight <= 0;
    @(negedge clk);
    check(lockstep_mismatch_out, 0, "mismatch clears");
    y_output_enable_n <= 1;
    y_fight <= 32'h0000_0100;
    repeat (2) @(negedge clk);
    check(lockstep_mismatch_out, 0, "released y ignored");
    $display("lockstep test done");
    finish_test();
  end
endmodule : operand_parity_clocking_tb
